/* src/scl_super.sv */
// Stepper supervisor top: registers, stall detection, homing and travel limits.
`timescale 1ns/1ps
`default_nettype none
`include "scl_map.svh"
module scl_super #(
  parameter int HOLD_CYC = `SCL_HOLD_MS * (`SCL_CLK_HZ / 1000),
  parameter int TICK_CYC = `SCL_TICK_MS * (`SCL_CLK_HZ / 1000)
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Motion status and targets.
  input wire scl_pkg::scl_mot_t mot,
  input wire logic [31:0] tgt_pos,
  input wire logic tgt_new,
  // Load measurement.
  input wire logic [15:0] load_val,
  input wire logic load_meas,
  input wire logic [3:0] decay_band,
  // Switch inputs.
  input wire logic home_in,
  input wire logic lim_neg,
  input wire logic lim_pos,
  // Drive outputs.
  output scl_pkg::scl_cmd_t cmd,
  output scl_pkg::scl_lvl_t cur_lvl,
  output logic [7:0] cur_val,
  output logic mix_decay_en
);
  // Whole state of the supervisor.
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_off;
    logic [6:0] ctrl;
    logic [7:0] i_hold;
    logic [7:0] i_nom;
    logic [7:0] i_max;
    logic [15:0] sthr;
    logic [15:0] sdly;
    logic [3:0] mix;
    logic [31:0] sw_min;
    logic [31:0] sw_max;
    logic [31:0] rdata;
    logic [31:0] zero;
    scl_pkg::scl_hst_t hst;
    logic homed;
    logic [31:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic stall_ok;
    logic stop;
    logic mix_en;
    logic neg_prev;
    logic pos_prev;
    logic dir_prev;
    logic warn;
    logic [7:0] err;
    logic int_lim;
  } scl_st_t;
  scl_st_t st_ff;
  scl_st_t nxt_st;

  // Decoded terms.
  logic stall; // Load below threshold.
  logic home_act; // Home input at its active level.
  logic sw_en; // Software limits in force.
  logic sw_bad; // Minimum above maximum.
  logic dir_chg; // Travel direction reversed.
  logic trig_neg; // Negative switch raises a warning.
  logic trig_pos; // Positive switch raises a warning.
  logic home_hit; // Homing condition met this cycle.
  logic acc_rd; // Read taken in this address phase.
  scl_pkg::scl_hmode_t hmode; // Selected homing trigger.

  // Tells whether a position lies outside the software window.
  function automatic logic out_of_win(input logic [31:0] p, input logic [31:0] lo,
                                      input logic [31:0] hi);
    out_of_win = ($signed(p) < $signed(lo)) || ($signed(p) > $signed(hi));
  endfunction

  // Combinational decode shared by the next-state logic.
  always_comb begin
    hmode = scl_pkg::scl_hmode_t'(st_ff.ctrl[`SCL_B_HMODE]);
    stall = load_val < st_ff.sthr;
    home_act = (hmode == scl_pkg::HM_HIGH) ? home_in : !home_in;
    sw_en = (st_ff.sw_min != '0) || (st_ff.sw_max != '0);
    sw_bad = $signed(st_ff.sw_min) > $signed(st_ff.sw_max);
    dir_chg = mot.moving && (mot.dir_pos != st_ff.dir_prev);
    if (st_ff.ctrl[`SCL_B_DIRMON]) begin
      // Each switch only counts in its own commanded direction.
      trig_neg = lim_neg && !mot.dir_pos && mot.moving && (!st_ff.neg_prev || dir_chg);
      trig_pos = lim_pos && mot.dir_pos && mot.moving && (!st_ff.pos_prev || dir_chg);
    end else begin
      // A fresh edge, or a reversal onto a switch passed while braking.
      trig_neg = lim_neg && (!st_ff.neg_prev || dir_chg);
      trig_pos = lim_pos && (!st_ff.pos_prev || dir_chg);
    end
    unique case (st_ff.hst)
      scl_pkg::HS_SEEK: begin
        home_hit = (hmode == scl_pkg::HM_STALL) ? st_ff.stall_ok : home_act;
      end
      default: begin
        home_hit = 1'b0;
      end
    endcase
    acc_rd = hsel && hready && htrans == `SCL_HTRANS_NONSEQ && !hwrite;
  end

  // Next-state logic of the whole supervisor.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stop = 1'b0;
    nxt_st.ctrl[`SCL_B_HSTART] = 1'b0;
    nxt_st.ctrl[`SCL_B_ACK] = 1'b0;
    nxt_st.neg_prev = lim_neg;
    nxt_st.pos_prev = lim_pos;
    if (mot.moving) begin
      nxt_st.dir_prev = mot.dir_pos;
    end

    // Data phase of a write: store into the addressed register.
    nxt_st.wr_pend = hsel && hready && htrans == `SCL_HTRANS_NONSEQ && hwrite;
    if (nxt_st.wr_pend) begin
      nxt_st.wr_off = haddr[7:0];
    end
    if (st_ff.wr_pend) begin
      unique case (st_ff.wr_off)
        `SCL_OFF_CTRL: nxt_st.ctrl = hwdata[6:0];
        `SCL_OFF_IHOLD: nxt_st.i_hold = hwdata[7:0];
        `SCL_OFF_INOM: nxt_st.i_nom = hwdata[7:0];
        `SCL_OFF_IMAX: nxt_st.i_max = hwdata[7:0];
        `SCL_OFF_STHR: nxt_st.sthr = hwdata[15:0];
        `SCL_OFF_SDLY: nxt_st.sdly = hwdata[15:0];
        `SCL_OFF_MIX: nxt_st.mix = hwdata[3:0];
        `SCL_OFF_SWMIN: nxt_st.sw_min = hwdata;
        `SCL_OFF_SWMAX: nxt_st.sw_max = hwdata;
        default: begin
          // Read-only and unmapped words ignore writes.
        end
      endcase
    end

    // Address phase of a read: fetch the word for the data phase.
    if (acc_rd) begin
      unique case (haddr[7:0])
        `SCL_OFF_CTRL: nxt_st.rdata = {25'h0, st_ff.ctrl};
        `SCL_OFF_IHOLD: nxt_st.rdata = {24'h0, st_ff.i_hold};
        `SCL_OFF_INOM: nxt_st.rdata = {24'h0, st_ff.i_nom};
        `SCL_OFF_IMAX: nxt_st.rdata = {24'h0, st_ff.i_max};
        `SCL_OFF_STHR: nxt_st.rdata = {16'h0, st_ff.sthr};
        `SCL_OFF_SDLY: nxt_st.rdata = {16'h0, st_ff.sdly};
        `SCL_OFF_MIX: nxt_st.rdata = {28'h0, st_ff.mix};
        `SCL_OFF_SWMIN: nxt_st.rdata = st_ff.sw_min;
        `SCL_OFF_SWMAX: nxt_st.rdata = st_ff.sw_max;
        `SCL_OFF_STAT: begin
          nxt_st.rdata = '0;
          nxt_st.rdata[`SCL_B_BUSY] = st_ff.hst != scl_pkg::HS_IDLE;
          nxt_st.rdata[`SCL_B_HOMED] = st_ff.homed;
          nxt_st.rdata[`SCL_B_STALL] = stall;
          nxt_st.rdata[`SCL_B_INTLIM] = st_ff.int_lim;
          nxt_st.rdata[`SCL_B_WARN] = st_ff.warn;
          if (st_ff.ctrl[`SCL_B_LDSHOW]) begin
            nxt_st.rdata[`SCL_B_LOAD] = load_val;
          end
        end
        `SCL_OFF_ERR: nxt_st.rdata = {24'h0, st_ff.err};
        `SCL_OFF_ZERO: nxt_st.rdata = st_ff.zero;
        default: nxt_st.rdata = '0;
      endcase
    end

    // Stall persistence: count whole milliseconds of continuous stall.
    if (!stall) begin
      nxt_st.tick_cnt = '0;
      nxt_st.ms_cnt = '0;
      nxt_st.stall_ok = 1'b0;
    end else if (st_ff.ms_cnt >= st_ff.sdly) begin
      nxt_st.stall_ok = 1'b1;
    end else if (st_ff.tick_cnt >= 32'(TICK_CYC - 1)) begin
      nxt_st.tick_cnt = '0;
      nxt_st.ms_cnt = st_ff.ms_cnt + 16'h1;
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + 32'h1;
    end

    // Mixed decay goes off during measurement from the threshold band upward; threshold fifteen keeps it on.
    nxt_st.mix_en = (st_ff.mix == `SCL_MIX_ALWAYS) || !load_meas
                    || (decay_band < st_ff.mix);

    // Homing sequencer.
    unique case (st_ff.hst)
      scl_pkg::HS_IDLE: begin
        // A start while moving is ignored; the start bit clears after one cycle either way.
        if (st_ff.ctrl[`SCL_B_HSTART] && !mot.moving) begin
          nxt_st.homed = 1'b0;
          unique case (hmode)
            scl_pkg::HM_IMM: begin
              nxt_st.zero = mot.pos;
              nxt_st.homed = 1'b1;
            end
            scl_pkg::HM_STALL: nxt_st.hst = scl_pkg::HS_SEEK;
            default: nxt_st.hst = home_act ? scl_pkg::HS_BACK : scl_pkg::HS_SEEK;
          endcase
        end
      end
      scl_pkg::HS_BACK: begin
        // Back off until the input clears, then seek it again.
        if (!home_act) begin
          nxt_st.hst = scl_pkg::HS_SEEK;
        end
      end
      scl_pkg::HS_SEEK: begin
        if (home_hit) begin
          nxt_st.zero = mot.pos;
          nxt_st.homed = 1'b1;
          nxt_st.stop = 1'b1;
          nxt_st.hst = scl_pkg::HS_IDLE;
        end
      end
    endcase

    // Limit switch warning: a new trigger wins over an acknowledge.
    if (st_ff.ctrl[`SCL_B_ACK]) begin
      nxt_st.warn = 1'b0;
      nxt_st.err = `SCL_ERR_NONE;
    end
    if (trig_neg || trig_pos) begin
      nxt_st.warn = 1'b1;
      nxt_st.err = trig_neg ? `SCL_ERR_NEG : `SCL_ERR_POS;
    end

    // Internal limit flag follows each new target and the window setup.
    if (sw_en && sw_bad) begin
      nxt_st.int_lim = 1'b1;
    end else if (tgt_new) begin
      nxt_st.int_lim = sw_en && out_of_win(tgt_pos, st_ff.sw_min, st_ff.sw_max);
    end

    if (srst) begin
      nxt_st = '0;
      nxt_st.i_hold = `SCL_RST_IHOLD;
      nxt_st.i_nom = `SCL_RST_INOM;
      nxt_st.i_max = `SCL_RST_IMAX;
      nxt_st.mix = `SCL_RST_MIX;
      nxt_st.mix_en = 1'b1;
    end
  end

  // Registers the state.
  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  // Current level selection.
  scl_cur_sel #(
    .HOLD_CYC(HOLD_CYC)
  ) u_cur (
    .ref_clk(ref_clk),
    .srst(srst),
    .phase(mot.phase),
    .homing(st_ff.hst != scl_pkg::HS_IDLE),
    .i_hold(st_ff.i_hold),
    .i_nom(st_ff.i_nom),
    .i_max(st_ff.i_max),
    .lvl(cur_lvl),
    .cur_val(cur_val)
  );

  // Drive commands; the warning ramps down without leaving the powered state.
  always_comb begin
    cmd.ramp_zero = st_ff.warn || st_ff.int_lim
                    || (sw_en && mot.moving && ((mot.dir_pos
                    && $signed(mot.pos) >= $signed(st_ff.sw_max))
                    || (!mot.dir_pos && $signed(mot.pos) <= $signed(st_ff.sw_min))));
    cmd.hard_stop = st_ff.stop;
    cmd.home_move = st_ff.hst != scl_pkg::HS_IDLE;
    cmd.home_dir_pos = (st_ff.hst == scl_pkg::HS_BACK) ? !st_ff.ctrl[`SCL_B_HDIR]
                       : st_ff.ctrl[`SCL_B_HDIR];
    cmd.block_dir = st_ff.ctrl[`SCL_B_DIRMON] && ((lim_neg && !mot.dir_pos)
                    || (lim_pos && mot.dir_pos));
  end

  assign mix_decay_en = st_ff.mix_en;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;

  // A seek that meets its condition latches the position and stops.
  home_latch_a: assert property (@(posedge ref_clk) disable iff (srst)
    home_hit |=> (st_ff.zero == $past(mot.pos)) && cmd.hard_stop && st_ff.homed)
    else $error("homing condition not latched");
  // Immediate homing latches without entering a move.
  imm_home_a: assert property (@(posedge ref_clk) disable iff (srst)
    (st_ff.hst == scl_pkg::HS_IDLE && st_ff.ctrl[`SCL_B_HSTART] && !mot.moving
     && hmode == scl_pkg::HM_IMM) |=> !cmd.home_move && st_ff.zero == $past(mot.pos))
    else $error("immediate homing misbehaved");
  // Stall confirmation is clear the cycle after the load is no longer below threshold.
  stall_gate_a: assert property (@(posedge ref_clk) disable iff (srst)
    !stall |=> !st_ff.stall_ok)
    else $error("stall confirmed without persistence");
  // Threshold fifteen leaves mixed decay on.
  mix_on_a: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.mix == `SCL_MIX_ALWAYS |=> mix_decay_en)
    else $error("mixed decay off at threshold fifteen");
  // A switch trigger warns and ramps down in the next cycle.
  lim_warn_a: assert property (@(posedge ref_clk) disable iff (srst)
    (trig_neg || trig_pos) |=> st_ff.warn && cmd.ramp_zero && st_ff.err != `SCL_ERR_NONE)
    else $error("limit switch not reported");
  // The negative switch held steady gives no new warning after acknowledge.
  lim_edge_a: assert property (@(posedge ref_clk) disable iff (srst)
    (lim_neg && $past(lim_neg) && !lim_pos && !dir_chg) |-> !trig_neg)
    else $error("limit retriggered without edge");
  // An out-of-window target raises the internal limit flag.
  sw_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
    (tgt_new && sw_en && out_of_win(tgt_pos, st_ff.sw_min, st_ff.sw_max)) |=> st_ff.int_lim)
    else $error("internal limit not flagged");
endmodule : scl_super
`default_nettype wire

/* src/scl_map.svh */
// Register offsets, field positions, reset values and timing figures of the supervisor.
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH
// Clock rate and documented times.
`define SCL_CLK_HZ 100000000
`define SCL_HOLD_MS 100
`define SCL_TICK_MS 1
// Register byte offsets.
`define SCL_OFF_CTRL 8'h00
`define SCL_OFF_IHOLD 8'h04
`define SCL_OFF_INOM 8'h08
`define SCL_OFF_IMAX 8'h0c
`define SCL_OFF_STHR 8'h10
`define SCL_OFF_SDLY 8'h14
`define SCL_OFF_MIX 8'h18
`define SCL_OFF_SWMIN 8'h1c
`define SCL_OFF_SWMAX 8'h20
`define SCL_OFF_STAT 8'h24
`define SCL_OFF_ERR 8'h28
`define SCL_OFF_ZERO 8'h2c
// Control register fields.
`define SCL_B_HSTART 0
`define SCL_B_HDIR 1
`define SCL_B_HMODE 3:2
`define SCL_B_DIRMON 4
`define SCL_B_ACK 5
`define SCL_B_LDSHOW 6
// Status register fields.
`define SCL_B_BUSY 0
`define SCL_B_HOMED 1
`define SCL_B_STALL 2
`define SCL_B_INTLIM 3
`define SCL_B_WARN 4
`define SCL_B_LOAD 31:16
// Values.
`define SCL_MIX_ALWAYS 4'hf
`define SCL_ERR_NONE 8'h00
`define SCL_ERR_NEG 8'h01
`define SCL_ERR_POS 8'h02
`define SCL_RST_IHOLD 8'h20
`define SCL_RST_INOM 8'h60
`define SCL_RST_IMAX 8'h80
`define SCL_RST_MIX 4'h8
`define SCL_HTRANS_NONSEQ 2'h2
`endif

/* src/scl_pkg.sv */
// Types shared by the stepper current, homing and limit supervisor.
package scl_pkg;
  // Motion phase reported by the ramp generator.
  typedef enum logic [1:0] {PH_STILL, PH_ACCEL, PH_CONST} scl_phase_t;
  // Coil current level, ranked from weakest to strongest.
  typedef enum logic [1:0] {LV_HOLD, LV_NOM, LV_MAX} scl_lvl_t;
  // Homing trigger selection.
  typedef enum logic [1:0] {HM_LOW, HM_HIGH, HM_STALL, HM_IMM} scl_hmode_t;
  // Homing sequencer state.
  typedef enum logic [1:0] {HS_IDLE, HS_SEEK, HS_BACK} scl_hst_t;
  // Motion status from the ramp generator and position counter.
  typedef struct packed {
    scl_phase_t phase;
    logic moving;
    logic dir_pos;
    logic [31:0] pos;
  } scl_mot_t;
  // Commands from the supervisor to the ramp generator.
  typedef struct packed {
    logic ramp_zero;
    logic hard_stop;
    logic home_move;
    logic home_dir_pos;
    logic block_dir;
  } scl_cmd_t;
endpackage : scl_pkg

/* src/scl_cur_sel.sv */
// Coil current level selection with release hold-off.
`timescale 1ns/1ps
`default_nettype none
`include "scl_map.svh"
module scl_cur_sel #(
  parameter int HOLD_CYC = `SCL_HOLD_MS * (`SCL_CLK_HZ / 1000),
  parameter int CW = 24
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Motion phase and homing activity.
  input wire scl_pkg::scl_phase_t phase,
  input wire logic homing,
  // Configured current values.
  input wire logic [7:0] i_hold,
  input wire logic [7:0] i_nom,
  input wire logic [7:0] i_max,
  // Applied level and value.
  output scl_pkg::scl_lvl_t lvl,
  output logic [7:0] cur_val
);
  // Whole state of this module.
  typedef struct packed {
    scl_pkg::scl_lvl_t lvl;
    logic [CW-1:0] cnt;
    logic [7:0] val;
  } scl_cs_t;
  scl_cs_t st_ff;
  scl_cs_t nxt_st;
  scl_pkg::scl_lvl_t want; // Level asked for by the present phase.

  // Picks the wanted level and holds a stronger one for the hold-off time.
  always_comb begin
    nxt_st = st_ff;
    unique case (phase)
      scl_pkg::PH_ACCEL: want = homing ? scl_pkg::LV_NOM : scl_pkg::LV_MAX;
      scl_pkg::PH_CONST: want = scl_pkg::LV_NOM;
      default: want = scl_pkg::LV_HOLD;
    endcase
    if (homing && st_ff.lvl == scl_pkg::LV_MAX) begin
      // Homing never keeps the maximum level, even during hold-off.
      nxt_st.lvl = scl_pkg::LV_NOM;
      nxt_st.cnt = '0;
    end else if (want >= st_ff.lvl) begin
      // Rank by level, not by value, so a stronger level takes over at once.
      nxt_st.lvl = want;
      nxt_st.cnt = '0;
    end else if (st_ff.cnt >= CW'(HOLD_CYC - 1)) begin
      nxt_st.lvl = want;
      nxt_st.cnt = '0;
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
    unique case (nxt_st.lvl)
      scl_pkg::LV_MAX: nxt_st.val = i_max;
      scl_pkg::LV_NOM: nxt_st.val = i_nom;
      default: nxt_st.val = i_hold;
    endcase
    if (srst) begin
      nxt_st = '0;
    end
  end

  // Registers the state.
  always_ff @(posedge ref_clk) begin
    st_ff <= nxt_st;
  end

  assign lvl = st_ff.lvl;
  assign cur_val = st_ff.val;

  // A drop to a weaker level waits out the hold-off.
  drop_wait_a: assert property (@(posedge ref_clk) disable iff (srst)
    (st_ff.lvl > want && !homing && st_ff.cnt == '0) |=> st_ff.lvl == $past(st_ff.lvl))
    else $error("current level dropped without hold-off");
  // From the second cycle of homing on, the level is never maximum current.
  home_nomax_a: assert property (@(posedge ref_clk) disable iff (srst)
    homing [*2] |-> st_ff.lvl != scl_pkg::LV_MAX)
    else $error("maximum current used while homing");
  // Acceleration outside homing gives maximum current next cycle.
  accel_max_a: assert property (@(posedge ref_clk) disable iff (srst)
    (phase == scl_pkg::PH_ACCEL && !homing) |=> st_ff.lvl == scl_pkg::LV_MAX)
    else $error("acceleration without maximum current");
endmodule : scl_cur_sel
`default_nettype wire

/* tb/scl_motor_model.sv */
// Stepper motor partner: position counter, homing travel and home cam.
`timescale 1ns/1ps
`default_nettype none
module scl_motor_model #(
  parameter logic [31:0] HOME_AT = 32'h0000_0040
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic srst,
  // Supervisor commands and the phase the bench plays.
  input wire scl_pkg::scl_cmd_t cmd,
  input wire scl_pkg::scl_phase_t phase,
  // Motion status and home cam.
  output scl_pkg::scl_mot_t mot,
  output logic home_in
);
  logic [31:0] pos_ff; // Shaft position in microsteps.
  logic dir_ff; // Last travel direction.
  logic mv_ff; // Registered motion flag, so no loop through cmd.
  logic run; // The shaft steps this cycle.
  // The shaft turns only while homing travel is asked and no stop is pending.
  assign run = cmd.home_move & ~cmd.hard_stop & ~cmd.ramp_zero;
  // One microstep a cycle in the commanded direction.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pos_ff <= 32'h0;
      dir_ff <= 1'b1;
      mv_ff <= 1'b0;
    end else begin
      mv_ff <= run;
      if (run) begin
        pos_ff <= cmd.home_dir_pos ? pos_ff + 32'h1 : pos_ff - 32'h1;
        dir_ff <= cmd.home_dir_pos;
      end
    end
  end
  // The cam closes at and above its position.
  assign home_in = (pos_ff >= HOME_AT);
  assign mot = '{phase: phase, moving: mv_ff, dir_pos: dir_ff, pos: pos_ff};
endmodule // scl_motor_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench of the stepper supervisor with its motor model.
`timescale 1ns/1ps
`default_nettype none
`include "scl_map.svh"
module tb;
  localparam int HOLD = 20; // Shortened current hold-off.
  localparam logic [31:0] HOME_AT = 32'h0000_0040; // Home cam position.
  logic ref_clk, srst, hsel, hwrite, hreadyout, hresp, tgt_new, load_meas;
  logic home_in, lim_neg, lim_pos, mix_decay_en;
  logic [31:0] haddr, hwdata, hrdata, tgt_pos, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] load_val;
  logic [3:0] decay_band;
  logic [7:0] cur_val;
  scl_pkg::scl_phase_t phase;
  scl_pkg::scl_mot_t mot;
  scl_pkg::scl_cmd_t cmd;
  scl_pkg::scl_lvl_t cur_lvl;
  int n_errors, samples_checked, i;
  // Design with short counts; the bus ready loops back from the slave.
  scl_super #(.HOLD_CYC(HOLD), .TICK_CYC(4)) u_dut (.ref_clk(ref_clk), .srst(srst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mot(mot), .tgt_pos(tgt_pos), .tgt_new(tgt_new),
    .load_val(load_val), .load_meas(load_meas), .decay_band(decay_band),
    .home_in(home_in), .lim_neg(lim_neg), .lim_pos(lim_pos), .cmd(cmd),
    .cur_lvl(cur_lvl), .cur_val(cur_val), .mix_decay_en(mix_decay_en));
  // Motor model on the far side.
  scl_motor_model #(.HOME_AT(HOME_AT)) u_mot (.ref_clk(ref_clk), .srst(srst),
    .cmd(cmd), .phase(phase), .mot(mot), .home_in(home_in));
  // Clock generator.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Compare one result and count it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One AHB-Lite single transfer; read data lands in q.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= `SCL_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // Register write, and masked register read against an expectation.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  // Let n edges pass, then stop at the falling edge where outputs are settled.
  task automatic at(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // Apply a new target for one cycle.
  task automatic aim(input logic [31:0] v);
    @(posedge ref_clk);
    tgt_pos <= v;
    tgt_new <= 1'b1;
    @(posedge ref_clk);
    tgt_new <= 1'b0;
  endtask
  // Poll the busy bit under a bounded count.
  task automatic wait_idle();
    for (int i = 0; i < 60; i++) begin
      bus(1'b0, `SCL_OFF_STAT, 32'h0);
      if (q[0] === 1'b0) break;
    end
    chk({31'h0, q[0]}, 32'h0);
  endtask
  // Print the verdict and stop.
  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    {srst, hsel, hwrite, tgt_new, load_meas, lim_neg, lim_pos} = 7'h40;
    {haddr, hwdata, tgt_pos} = '0;
    {htrans, hsize, decay_band} = 9'h020;
    load_val = 16'hffff;
    phase = scl_pkg::PH_STILL;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    at(2);
    chk({30'h0, cur_lvl}, {30'h0, scl_pkg::LV_HOLD});
    chk({30'h0, hreadyout, hresp}, 32'h2); // Bus answers at once with OKAY.
    rd(`SCL_OFF_IHOLD, 32'hffffffff, 32'h20);
    rd(`SCL_OFF_INOM, 32'hffffffff, 32'h60);
    rd(`SCL_OFF_IMAX, 32'hffffffff, 32'h80);
    rd(`SCL_OFF_MIX, 32'hffffffff, 32'h8);
    rd(8'h40, 32'hffffffff, 32'h0); // Unmapped place reads zero.
    // Current levels by phase, with the drop hold-off.
    @(posedge ref_clk) phase <= scl_pkg::PH_ACCEL;
    at(2);
    chk({22'h0, cur_lvl, cur_val}, {22'h0, scl_pkg::LV_MAX, 8'h80});
    @(posedge ref_clk) phase <= scl_pkg::PH_CONST;
    at(3);
    chk({30'h0, cur_lvl}, {30'h0, scl_pkg::LV_MAX});
    at(HOLD);
    chk({22'h0, cur_lvl, cur_val}, {22'h0, scl_pkg::LV_NOM, 8'h60});
    wr(`SCL_OFF_IHOLD, 32'hf0);
    @(posedge ref_clk) phase <= scl_pkg::PH_STILL;
    at(3);
    chk({30'h0, cur_lvl}, {30'h0, scl_pkg::LV_NOM});
    at(HOLD);
    chk({22'h0, cur_lvl, cur_val}, {22'h0, scl_pkg::LV_HOLD, 8'hf0});
    // Mixed decay during load measurement.
    wr(`SCL_OFF_MIX, 32'h4);
    @(posedge ref_clk) {load_meas, decay_band} <= 5'h14;
    at(2);
    chk({31'h0, mix_decay_en}, 32'h0);
    @(posedge ref_clk) decay_band <= 4'h3;
    at(2);
    chk({31'h0, mix_decay_en}, 32'h1);
    wr(`SCL_OFF_MIX, 32'hf);
    @(posedge ref_clk) decay_band <= 4'hf;
    at(2);
    chk({31'h0, mix_decay_en}, 32'h1);
    @(posedge ref_clk) load_meas <= 1'b0;
    // Stall flag is strict below the threshold; load shown on request.
    wr(`SCL_OFF_STHR, 32'h100);
    @(posedge ref_clk) load_val <= 16'h0100;
    rd(`SCL_OFF_STAT, 32'h4, 32'h0);
    @(posedge ref_clk) load_val <= 16'h00ff;
    rd(`SCL_OFF_STAT, 32'h4, 32'h4);
    wr(`SCL_OFF_CTRL, 32'h40);
    rd(`SCL_OFF_STAT, 32'hffff0000, 32'h00ff0000);
    @(posedge ref_clk) load_val <= 16'hffff;
    // Homing on a high level, forward, with the cam open at start.
    @(posedge ref_clk) phase <= scl_pkg::PH_ACCEL;
    wr(`SCL_OFF_CTRL, 32'h7);
    at(4);
    chk({28'h0, cmd.home_move, cmd.home_dir_pos, cur_lvl}, 32'hd);
    wait_idle();
    rd(`SCL_OFF_ZERO, 32'hffffffff, HOME_AT);
    rd(`SCL_OFF_STAT, 32'h2, 32'h2);
    // Second run starts on the cam: back off, then return.
    wr(`SCL_OFF_CTRL, 32'h7);
    at(3);
    chk({30'h0, cmd.home_move, cmd.home_dir_pos}, 32'h2);
    wait_idle();
    rd(`SCL_OFF_ZERO, 32'hffffffff, HOME_AT);
    @(posedge ref_clk) phase <= scl_pkg::PH_STILL;
    // Immediate homing takes the position without motion.
    wr(`SCL_OFF_CTRL, 32'hd);
    at(3);
    chk({31'h0, cmd.home_move}, 32'h0);
    rd(`SCL_OFF_ZERO, 32'hffffffff, mot.pos);
    // Stall homing: a short stall is ignored, a lasting one latches and stops at once.
    wr(`SCL_OFF_SDLY, 32'h2);
    wr(`SCL_OFF_CTRL, 32'hb);
    @(posedge ref_clk) load_val <= 16'h00ff;
    repeat (4) @(posedge ref_clk);
    load_val <= 16'hffff;
    at(12);
    chk({31'h0, cmd.home_move}, 32'h1);
    @(posedge ref_clk) load_val <= 16'h00ff;
    for (i = 1; i < 40 && cmd.hard_stop !== 1'b1; i++) @(negedge ref_clk);
    chk({31'h0, i > 9 && i < 15}, 32'h1);
    load_val <= 16'hffff;
    wait_idle();
    rd(`SCL_OFF_ZERO, 32'hffffffff, mot.pos - 32'h1);
    // Low level homing backward from above the cam.
    wr(`SCL_OFF_CTRL, 32'h1);
    wait_idle();
    rd(`SCL_OFF_ZERO, 32'hffffffff, HOME_AT - 32'h1);
    // Hardware limit switches, acknowledge and held switch.
    @(posedge ref_clk) lim_pos <= 1'b1;
    at(2);
    chk({31'h0, cmd.ramp_zero}, 32'h1);
    rd(`SCL_OFF_ERR, 32'hff, `SCL_ERR_POS);
    rd(`SCL_OFF_STAT, 32'h10, 32'h10);
    wr(`SCL_OFF_CTRL, 32'h20);
    at(2);
    chk({31'h0, cmd.ramp_zero}, 32'h0);
    rd(`SCL_OFF_STAT, 32'h10, 32'h0);
    @(posedge ref_clk) {lim_neg, lim_pos} <= 2'h2;
    rd(`SCL_OFF_ERR, 32'hff, `SCL_ERR_NEG);
    wr(`SCL_OFF_CTRL, 32'h20);
    @(posedge ref_clk) lim_neg <= 1'b0;
    // Direction monitoring: a switch in the last travel direction blocks it, and at standstill gives no warning.
    wr(`SCL_OFF_CTRL, 32'h10);
    @(posedge ref_clk) lim_neg <= 1'b1;
    at(2);
    chk({30'h0, cmd.block_dir, cmd.ramp_zero}, 32'h2);
    @(posedge ref_clk) lim_neg <= 1'b0;
    // Software limits: out of range, back in range, inconsistent window.
    wr(`SCL_OFF_SWMIN, 32'h10);
    wr(`SCL_OFF_SWMAX, 32'h100);
    aim(32'h200);
    at(2);
    chk({31'h0, cmd.ramp_zero}, 32'h1);
    rd(`SCL_OFF_STAT, 32'h8, 32'h8);
    aim(32'h80);
    rd(`SCL_OFF_STAT, 32'h8, 32'h0);
    wr(`SCL_OFF_SWMIN, 32'h200);
    rd(`SCL_OFF_STAT, 32'h8, 32'h8);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
